// file: rtl/sfb_top.sv
// Shared byte FIFO with APB registers, alerts and interrupt
// Functional notes
// - Internal command logic reads and writes the buffer during a command.
// - Flush bit write resets pointers and clears fill level.
// - Capacity 512 bytes with size bit 0, 255 bytes with size bit 1.
// - Each buffer write adds one to fill level unless full, each read subtracts one unless empty.
// - Large mode: upper fill level bits sit in control register.
// - Threshold is nine bits: low byte at index 3, MSB control bit 2.
// - One threshold governs both alerts, full from top, empty from bottom.
// - Almost full when capacity minus fill level is at most threshold.
// - Almost empty when fill level is at most threshold.
// - Write into full buffer sets overflow, seen as error interrupt flag.
// - Almost-empty enable raises interrupt on rising almost-empty flag.
// - Almost-full enable raises interrupt on rising almost-full flag.
// - Small mode uses one threshold byte; large mode adds control bit 2 as its MSB.
module sfb_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_wr,
    input wire logic [7:0] core_wdata,
    input wire logic core_rd,
    output logic [7:0] core_rdata,
    output logic core_rvalid,
    output logic irq
);
    logic [1:0] rst_sync;
    logic rst_n;
    sfb_pkg::sfb_state_t state;
    logic [sfb_pkg::PTR_W-1:0] wr_ptr;
    logic [sfb_pkg::PTR_W-1:0] rd_ptr;
    logic [sfb_pkg::CNT_W-1:0] count;
    logic size_sel;
    logic thr_msb;
    logic [7:0] thr_low;
    logic [sfb_pkg::IRQ_W-1:0] irq_status;
    logic [sfb_pkg::IRQ_W-1:0] irq_enable;
    logic af_q;
    logic ae_q;

    sfb_mem_if mif ();

    sfb_mem u_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .m(mif.store)
    );

    // Reset release through two flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Bus decode
    wire [sfb_pkg::IDX_W-1:0] idx = paddr[sfb_pkg::IDX_W+1:2];
    wire mapped = (paddr[11:5] == 7'h00) && (idx <= sfb_pkg::IDX_LAST);
    wire acc = psel && penable && (state == sfb_pkg::SFB_IDLE);
    wire sel_data = mapped && (idx == sfb_pkg::IDX_DATA);
    wire core_req = core_wr || core_rd;
    // Command logic owns the store in its cycles; host data access waits
    wire host_stall = acc && sel_data && core_req;
    wire take = acc && !host_stall;
    wire reg_wr = take && pwrite && mapped;
    wire h_push = take && pwrite && sel_data;
    wire h_pop = take && !pwrite && sel_data;
    wire wr_status = reg_wr && (idx == sfb_pkg::IDX_IRQ_STATUS);
    wire wr_enable = reg_wr && (idx == sfb_pkg::IDX_IRQ_ENABLE);
    wire wr_ctrl = reg_wr && (idx == sfb_pkg::IDX_CTRL);
    wire wr_thr = reg_wr && (idx == sfb_pkg::IDX_THR_LOW);
    wire flush = wr_ctrl && pwdata[sfb_pkg::CTRL_FLUSH];

    // Capacity and level
    wire [sfb_pkg::CNT_W-1:0] cap = size_sel ? sfb_pkg::CAP_SMALL : sfb_pkg::CAP_LARGE;
    wire [sfb_pkg::PTR_W-1:0] last_ptr = sfb_pkg::PTR_W'(cap - 10'h001);
    wire full = (count == cap);
    wire empty = (count == 10'h000);
    wire push = h_push || core_wr;
    wire pop = h_pop || core_rd;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;
    wire overflow = push && full;
    wire [sfb_pkg::PTR_W-1:0] wr_inc = (wr_ptr >= last_ptr) ? 9'h000 : wr_ptr + 9'h001;
    wire [sfb_pkg::PTR_W-1:0] rd_inc = (rd_ptr >= last_ptr) ? 9'h000 : rd_ptr + 9'h001;
    wire [sfb_pkg::CNT_W-1:0] next_count = flush ? 10'h000 :
        count + {9'h000, do_push} - {9'h000, do_pop};

    // Threshold; the MSB only counts in large mode
    wire [sfb_pkg::CNT_W-1:0] thr = {1'b0, thr_msb && !size_sel, thr_low};
    // Cannot wrap below zero unless size shrinks with data held
    wire [sfb_pkg::CNT_W-1:0] free_space = cap - count;
    wire almost_full = (free_space <= thr);
    wire almost_empty = (count <= thr);

    // Interrupt events; set wins over a same-cycle clear
    wire [sfb_pkg::IRQ_W-1:0] irq_set = {
        almost_full && !af_q,
        almost_empty && !ae_q,
        overflow
    };
    wire [sfb_pkg::IRQ_W-1:0] irq_clr = wr_status ? pwdata[sfb_pkg::IRQ_W-1:0] : 3'h0;
    wire [sfb_pkg::IRQ_W-1:0] next_status = (irq_status & ~irq_clr) | irq_set;

    // Read data selection
    wire [7:0] ctrl_rd = {1'b0, size_sel, almost_full, almost_empty, 1'b0, thr_msb,
        count[9:8]};
    wire [7:0] reg_rd =
        (idx == sfb_pkg::IDX_IRQ_STATUS) ? {5'h00, irq_status} :
        (idx == sfb_pkg::IDX_IRQ_ENABLE) ? {5'h00, irq_enable} :
        (idx == sfb_pkg::IDX_CTRL) ? ctrl_rd :
        (idx == sfb_pkg::IDX_THR_LOW) ? thr_low :
        (idx == sfb_pkg::IDX_FILL) ? count[7:0] : 8'h00;

    // Store ports
    assign mif.we = do_push && !flush;
    assign mif.waddr = wr_ptr;
    assign mif.wdata = core_wr ? core_wdata : pwdata[7:0];
    assign mif.re = do_pop && !flush;
    assign mif.raddr = rd_ptr;
    assign core_rdata = mif.rdata;

    // Pointers and level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            count <= 10'h000;
        end else begin
            count <= next_count;
            if (flush) begin
                wr_ptr <= 9'h000;
                rd_ptr <= 9'h000;
            end else begin
                if (do_push) begin
                    wr_ptr <= wr_inc;
                end
                if (do_pop) begin
                    rd_ptr <= rd_inc;
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            size_sel <= 1'b0;
            thr_msb <= 1'b0;
            thr_low <= sfb_pkg::THR_RESET;
            irq_enable <= sfb_pkg::IRQ_ENABLE_RESET;
        end else begin
            if (wr_ctrl) begin
                size_sel <= pwdata[sfb_pkg::CTRL_SIZE];
                thr_msb <= pwdata[sfb_pkg::CTRL_THR_MSB];
            end
            if (wr_thr) begin
                thr_low <= pwdata[7:0];
            end
            if (wr_enable) begin
                irq_enable <= pwdata[sfb_pkg::IRQ_W-1:0];
            end
        end
    end

    // Alert history, status and interrupt pin
    // Empty history starts high so reset release gives no false rise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            af_q <= 1'b0;
            ae_q <= 1'b1;
            irq_status <= 3'h0;
            irq <= 1'b0;
            core_rvalid <= 1'b0;
        end else begin
            af_q <= almost_full;
            ae_q <= almost_empty;
            irq_status <= next_status;
            irq <= |(next_status & irq_enable);
            core_rvalid <= core_rd && !empty && !flush;
        end
    end

    // APB answer: register access two cycles, data read three
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sfb_pkg::SFB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            unique case (state)
                sfb_pkg::SFB_IDLE: begin
                    if (take) begin
                        pslverr <= !mapped;
                        if (h_pop) begin
                            state <= sfb_pkg::SFB_WAIT;
                        end else begin
                            state <= sfb_pkg::SFB_DONE;
                            pready <= 1'b1;
                            prdata <= {24'h000000, pwrite ? 8'h00 : reg_rd};
                        end
                    end
                end
                sfb_pkg::SFB_WAIT: begin
                    // Empty read returns the byte last read out of the store
                    state <= sfb_pkg::SFB_DONE;
                    pready <= 1'b1;
                    prdata <= {24'h000000, mif.rdata};
                end
                sfb_pkg::SFB_DONE: begin
                    state <= sfb_pkg::SFB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    a_flush_clears: assert property (@(posedge mclk) disable iff (!rst_n)
        flush |=> (count == 10'h000) && (wr_ptr == 9'h000) && (rd_ptr == 9'h000))
        else $error("flush did not clear level and pointers");

    a_level_step: assert property (@(posedge mclk) disable iff (!rst_n)
        (!flush && do_push && !do_pop) |=> count == $past(count) + 10'h001)
        else $error("level did not rise by one on push");

    a_level_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        (!flush && do_pop && !do_push) |=> count == $past(count) - 10'h001)
        else $error("level did not fall by one on pop");

    a_level_cap: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(wr_ctrl) |-> count <= cap)
        else $error("level exceeds capacity");

    a_wrap_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (do_push && !flush && (wr_ptr == last_ptr)) |=> (wr_ptr == 9'h000))
        else $error("write pointer did not wrap at capacity");

    a_wrap_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (do_pop && !flush && (rd_ptr == last_ptr)) |=> (rd_ptr == 9'h000))
        else $error("read pointer did not wrap at capacity");

    a_empty_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (pop && empty && !push) |=> (count == 10'h000) && $stable(rd_ptr))
        else $error("empty read changed level or pointer");

    a_overflow_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (h_push && full) |=> irq_status[sfb_pkg::IRQ_ERR])
        else $error("overflow flag not set on write into full buffer");

    a_overflow_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        (push && full && !pop && !flush) |=> count == $past(count))
        else $error("write into full buffer changed the level");

    a_full_alert: assert property (@(posedge mclk) disable iff (!rst_n)
        ctrl_rd[sfb_pkg::CTRL_AF] == (({1'b0, count} + {1'b0, thr}) >= {1'b0, cap}))
        else $error("almost full flag wrong");

    a_empty_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        (count == thr) |-> ctrl_rd[sfb_pkg::CTRL_AE])
        else $error("almost empty flag low at threshold level");

    a_small_thr: assert property (@(posedge mclk) disable iff (!rst_n)
        (size_sel && (count > {2'b00, thr_low})) |-> !ctrl_rd[sfb_pkg::CTRL_AE])
        else $error("threshold MSB counted in small mode");

    a_ae_interrupt: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(almost_empty) && irq_enable[sfb_pkg::IRQ_AE]) |=> irq)
        else $error("almost empty rise did not raise interrupt");

    a_af_interrupt: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(almost_full) && irq_enable[sfb_pkg::IRQ_AF])
        |=> irq && irq_status[sfb_pkg::IRQ_AF])
        else $error("almost full rise did not raise interrupt");

    a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        irq == |(irq_status & $past(irq_enable)))
        else $error("interrupt pin does not follow enabled status");

    a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        (core_rd && !empty && !flush) |=> core_rvalid)
        else $error("command logic read not answered");

    a_host_waits: assert property (@(posedge mclk) disable iff (!rst_n)
        host_stall |=> !pready && (state == sfb_pkg::SFB_IDLE))
        else $error("host data access not held off by command logic");

    a_ready_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        pready |=> !pready ##1 (state == sfb_pkg::SFB_IDLE))
        else $error("pready longer than one cycle");
endmodule // sfb_top

// file: common/sfb_pkg.sv
// Constants for the shared byte FIFO block
package sfb_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PTR_W = 9;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned IDX_W = 3;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 3'h0;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 3'h1;
    localparam logic [IDX_W-1:0] IDX_CTRL = 3'h2;
    localparam logic [IDX_W-1:0] IDX_THR_LOW = 3'h3;
    localparam logic [IDX_W-1:0] IDX_FILL = 3'h4;
    localparam logic [IDX_W-1:0] IDX_DATA = 3'h5;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;
    // Control register fields
    localparam int unsigned CTRL_FLUSH = 7;
    localparam int unsigned CTRL_SIZE = 6;
    localparam int unsigned CTRL_AF = 5;
    localparam int unsigned CTRL_AE = 4;
    localparam int unsigned CTRL_THR_MSB = 2;
    // Interrupt status and enable fields
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_ERR = 0;
    localparam int unsigned IRQ_AE = 1;
    localparam int unsigned IRQ_AF = 2;
    // Capacities
    localparam logic [CNT_W-1:0] CAP_LARGE = 10'h200;
    localparam logic [CNT_W-1:0] CAP_SMALL = 10'h0FF;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic [7:0] THR_RESET = 8'h08;
    typedef enum logic [1:0] {
        SFB_IDLE,
        SFB_WAIT,
        SFB_DONE
    } sfb_state_t;
endpackage

// file: common/sfb_mem_if.sv
// Carrier between the FIFO controller and its byte store
interface sfb_mem_if;
    logic we;
    logic re;
    logic [8:0] waddr;
    logic [8:0] raddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output re, output waddr, output raddr, output wdata, input rdata);
    modport store (input we, input re, input waddr, input raddr, input wdata, output rdata);
endinterface

// file: rtl/sfb_mem.sv
// 512 x 8 byte store with registered read data
module sfb_mem (
    input wire logic mclk,
    input wire logic rst_n,
    sfb_mem_if.store m
);
    logic [7:0] mem [512];

    always_ff @(posedge mclk) begin
        if (m.we) begin
            mem[m.waddr] <= m.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m.rdata <= 8'h00;
        end else if (m.re) begin
            m.rdata <= mem[m.raddr];
        end
    end
endmodule // sfb_mem

// file: verification/sfb_core_model.sv
// Command-logic side model driving the FIFO core port
module sfb_core_model (
    input wire logic mclk,
    output logic core_wr,
    output logic [7:0] core_wdata,
    output logic core_rd,
    input wire logic [7:0] core_rdata,
    input wire logic core_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        core_wr = 1'b0;
        core_rd = 1'b0;
        core_wdata = 8'h00;
    end
    // Host data access is held off by the block while a burst runs
    task automatic push_run(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            core_wr <= 1'b1;
            core_wdata <= base + 8'(i);
            @(posedge mclk);
        end
        core_wr <= 1'b0;
        // Released data must not keep the last byte
        core_wdata <= ~core_wdata;
    endtask
    task automatic pop_one(output logic [7:0] b, output logic ok);
        core_rd <= 1'b1;
        @(posedge mclk);
        core_rd <= 1'b0;
        @(posedge mclk);
        b = core_rdata;
        ok = core_rvalid;
    endtask
endmodule // sfb_core_model

// file: verification/tb_shared_fifo_buffer_control.sv
// Self-checking bench for the shared byte FIFO block
module tb_shared_fifo_buffer_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] I_ST = sfb_pkg::IDX_IRQ_STATUS;
    localparam logic [2:0] I_EN = sfb_pkg::IDX_IRQ_ENABLE;
    localparam logic [2:0] I_CT = sfb_pkg::IDX_CTRL;
    localparam logic [2:0] I_TH = sfb_pkg::IDX_THR_LOW;
    localparam logic [2:0] I_FL = sfb_pkg::IDX_FILL;
    localparam logic [2:0] I_DA = sfb_pkg::IDX_DATA;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_wr;
    logic [7:0] core_wdata;
    logic core_rd;
    logic [7:0] core_rdata;
    logic core_rvalid;
    logic irq;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] b;
    logic ok;

    always #10 mclk = ~mclk;

    sfb_top dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_wr(core_wr), .core_wdata(core_wdata), .core_rd(core_rd),
        .core_rdata(core_rdata), .core_rvalid(core_rvalid), .irq(irq));

    sfb_core_model core (.mclk(mclk), .core_wr(core_wr), .core_wdata(core_wdata),
        .core_rd(core_rd), .core_rdata(core_rdata), .core_rvalid(core_rvalid));

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is sampled high, then released
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~wd;
            @(posedge mclk);
        end
    endtask

    task wr(input logic [2:0] i, input logic [31:0] v);
        apb(1'b1, {7'h00, i, 2'b00}, v);
    endtask

    task rdc(input logic [2:0] i, input logic [31:0] exp);
        apb(1'b0, {7'h00, i, 2'b00}, 32'h0);
        chk(rd, exp);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc(I_TH, 32'h08);
        rdc(I_CT, 32'h10);
        rdc(I_EN, 32'h0);
        wr(I_TH, 32'h03);
        wr(I_EN, 32'h06);
        core.push_run(4, 8'hA0);
        rdc(I_DA, 32'hA0);
        rdc(I_FL, 32'h03);
        rdc(I_ST, 32'h02);
        chk(irq, 32'h1);
        wr(I_ST, 32'h02);
        chk(irq, 32'h0);
        wr(I_DA, 32'h5C);
        rdc(I_FL, 32'h04);
        wr(I_CT, 32'h80);
        rdc(I_FL, 32'h00);
        rdc(I_CT, 32'h10);
        wr(I_ST, 32'h07);
        // Small capacity, threshold MSB set but ignored; then one host byte too many
        wr(I_CT, 32'h44);
        core.push_run(255, 8'h00);
        rdc(I_FL, 32'hFF);
        rdc(I_CT, 32'h64);
        rdc(I_ST, 32'h04);
        chk(irq, 32'h1);
        wr(I_DA, 32'h77);
        rdc(I_ST, 32'h05);
        rdc(I_FL, 32'hFF);
        wr(I_ST, 32'h07);
        // Large mode, nine-bit threshold 0x103, level 300
        wr(I_CT, 32'h84);
        core.push_run(300, 8'h00);
        rdc(I_CT, 32'h25);
        rdc(I_FL, 32'h2C);
        rdc(I_ST, 32'h06);
        core.pop_one(b, ok);
        chk(ok, 32'h1);
        chk(b, 32'h00);
        rdc(I_FL, 32'h2B);
        // Host data read held off while the command logic pushes
        fork
            core.push_run(3, 8'hB0);
            rdc(I_DA, 32'h01);
        join
        rdc(I_FL, 32'h2D);
        wr(I_CT, 32'h80);
        apb(1'b0, {7'h00, I_DA, 2'b00}, 32'h0);
        rdc(I_FL, 32'h00);
        wr(I_FL, 32'h55);
        rdc(I_CT, 32'h10);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        report_and_stop();
    end
endmodule // tb_shared_fifo_buffer_control
